// ### design/xbus_consts.vh
// Constants for the external parallel bus pin controller.
// Assumes inclusion by the bus controller module only.
// Function
// [R1] After reset port zero lines are open drain while pull-up is off.
// [R2] A port zero line with pull-up enabled acts quasi-bidirectional.
// [R3] During an access port zero drives push-pull and carries the data byte; the code floats port zero on reads.
// [R4] Multiplexed mode: port zero carries low address first, then data.
// [R5] During an access port two drives the upper address byte push-pull.
// [R6] Multiplexed mode drives an address latch strobe for the low byte.
// [R7] Window select is low only for accesses to 4000h through 7FFFh.
// [R8] An output shows the inverse of address bit 15.
// [R9] Direct mode puts the low six address bits on port four.
// [R10] Direct mode puts address bit 6 on a port three line.
// [R11] Direct mode puts address bit 7 on a port two line.
// [R12] Writes use store strobe, reads load strobe; partner obeys them.
// [R13] Direct 15-bit or multiplexed addressing is chosen by configuration.
// [R14] Four selectable speeds set the external cycle timing.
// [R15] One byte moves per access in classic external memory cycles.
// [R16] The address reaches external memory of up to 32KB.
// [R17] Speed configuration resets to all ones.
// [R18] Auxiliary configuration resets to all zeros.
// [R19] Strobes active low, exclusive; address stable around each strobe.
// [R20] Idle ports return to their software-set modes and values; port four keeps the last low address bits.
`ifndef XBUS_CONSTS_VH
`define XBUS_CONSTS_VH
`define SPEED_RESET   8'hFF
`define AUX_RESET     8'h00
`define AUX_MUX_BIT   0
`define WIN_LO        16'h4000
`define WIN_HI        16'h7FFF
`define A15_BIT       15
`define A6_BIT        6
`define A7_BIT        7
`define SETUP_CYC     4'h1
`define HOLD_CYC      4'h1
`define ALE_CYC       4'h1
`define RD_EXTRA      4'h4
`endif

// ### design/xbus_pins.v
// External parallel bus pin controller: overrides port drive during
// accesses, makes strobes, window select and inverted top address.
// Assumes a core request port on clk; pin inputs are asynchronous.
`timescale 1ns/1ps
`include "xbus_consts.vh"
module xbus_pins #(
  parameter SPW = 4
) (
  // Clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // Core request
  input  wire        req,
  input  wire        req_wr,
  input  wire [15:0] req_addr,
  input  wire [7:0]  req_wdata,
  output reg         busy_r,
  output reg         done_r,
  output reg  [7:0]  rdata_r,
  // Configuration
  input  wire        speed_we,
  input  wire [7:0]  speed_wdata,
  input  wire        aux_we,
  input  wire [7:0]  aux_wdata,
  output reg  [7:0]  speed_r,
  output reg  [7:0]  aux_r,
  // Software port settings
  input  wire [7:0]  port_zero_out,
  input  wire [7:0]  port_zero_dir,
  input  wire [7:0]  port_zero_pullup_enable,
  input  wire [7:0]  port_two_out,
  input  wire [7:0]  port_two_dir,
  // Port zero pins
  input  wire [7:0]  port_zero_in,
  output reg  [7:0]  port_zero_o_r,
  output reg  [7:0]  port_zero_oe_r,
  output reg  [7:0]  port_zero_pu_r,
  // Port two pins
  output reg  [7:0]  port_two_o_r,
  output reg  [7:0]  port_two_oe_r,
  // Bus control pins
  output reg  [5:0]  port_four_addr_r,
  output reg         direct_addr_bit6_r,
  output reg         direct_addr_bit7_r,
  output reg         address_latch_strobe_r,
  output reg         store_strobe_n_r,
  output reg         load_strobe_n_r,
  output reg         window_select_n_r,
  output reg         inverted_top_address_r
);

  localparam ST_IDLE  = 3'h0;
  localparam ST_ALE   = 3'h1;
  localparam ST_SETUP = 3'h2;
  localparam ST_STRB  = 3'h3;
  localparam ST_HOLD  = 3'h4;

  // Pin input synchroniser
  reg  [7:0] p0_s1_r;
  reg  [7:0] p0_s2_r;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      p0_s1_r <= 8'h00;
      p0_s2_r <= 8'h00;
    end else begin
      p0_s1_r <= port_zero_in;
      p0_s2_r <= p0_s1_r;
    end
  end

  // Configuration registers
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      speed_r <= `SPEED_RESET; // R17
      aux_r   <= `AUX_RESET; // R18
    end else begin
      if (speed_we)
        speed_r <= speed_wdata;
      if (aux_we)
        aux_r <= aux_wdata;
    end
  end

  // Speed: strobe width from low two bits of speed register
  wire [1:0]     spd = speed_r[1:0];
  wire [SPW-1:0] strb_len = {{(SPW-2){1'b0}}, spd} + 1'b1; // R14
  wire           mux_mode = aux_r[`AUX_MUX_BIT]; // R13

  // ==================================================
  // Access sequencer
  reg  [2:0]     st_r;
  reg  [SPW-1:0] cnt_r;
  reg  [15:0]    addr_r;
  reg  [7:0]     wdata_r;
  reg            wr_r;
  reg            mux_r;
  // Reads stretch the strobe past the pin synchroniser delay
  wire [SPW-1:0] rd_extra = `RD_EXTRA;
  wire [SPW-1:0] strb_end = wr_r ? (strb_len - 1'b1)
                                 : (strb_len + rd_extra - 1'b1); // R12

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r    <= ST_IDLE;
      cnt_r   <= {SPW{1'b0}};
      addr_r  <= 16'h0000;
      wdata_r <= 8'h00;
      wr_r    <= 1'b0;
      mux_r   <= 1'b0;
      done_r  <= 1'b0;
      rdata_r <= 8'h00;
    end else begin
      done_r <= 1'b0;
      case (st_r)
        ST_IDLE: begin
          if (req) begin
            addr_r  <= {1'b0, req_addr[14:0]} | // R16
                       ({15'h0000, req_addr[15]} << `A15_BIT);
            wdata_r <= req_wdata; // R15
            wr_r    <= req_wr;
            mux_r   <= mux_mode;
            cnt_r   <= {SPW{1'b0}};
            st_r    <= mux_mode ? ST_ALE : ST_SETUP;
          end
        end
        ST_ALE: begin
          st_r <= ST_SETUP; // R4
        end
        ST_SETUP: begin
          st_r  <= ST_STRB; // R19
          cnt_r <= {SPW{1'b0}};
        end
        ST_STRB: begin
          if (cnt_r == strb_end) begin
            if (!wr_r)
              rdata_r <= p0_s2_r;
            st_r <= ST_HOLD;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        ST_HOLD: begin
          done_r <= 1'b1;
          st_r   <= ST_IDLE;
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // ==================================================
  // Pin drive, next values
  wire act_nxt = (st_r != ST_IDLE) && !(st_r == ST_HOLD);
  wire in_win  = (addr_r >= `WIN_LO) && (addr_r <= `WIN_HI);
  reg  [7:0] p0_o_nxt;
  reg  [7:0] p0_oe_nxt;
  reg  [7:0] p2_o_nxt;
  reg  [7:0] p2_oe_nxt;

  always @* begin
    p0_o_nxt  = port_zero_out;
    // Open drain: drive only low; pull-up gives quasi mode
    p0_oe_nxt = port_zero_dir & ~port_zero_out; // R1 R2
    p2_o_nxt  = port_two_out;
    p2_oe_nxt = port_two_dir; // R20
    if (act_nxt || st_r == ST_HOLD) begin
      p2_o_nxt  = addr_r[15:8]; // R5
      p2_oe_nxt = 8'hFF;
      if (!mux_r)
        p2_o_nxt[`A7_BIT] = addr_r[`A7_BIT]; // R11
      if (st_r == ST_ALE) begin
        p0_o_nxt  = addr_r[7:0]; // R4
        p0_oe_nxt = 8'hFF;
      end else if (wr_r) begin
        p0_o_nxt  = wdata_r; // R3
        p0_oe_nxt = 8'hFF;
      end else begin
        p0_o_nxt  = 8'h00;
        p0_oe_nxt = 8'h00; // R12
      end
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      port_zero_o_r          <= 8'h00;
      port_zero_oe_r         <= 8'h00;
      port_zero_pu_r         <= 8'h00;
      port_two_o_r           <= 8'h00;
      port_two_oe_r          <= 8'h00;
      port_four_addr_r       <= 6'h00;
      direct_addr_bit6_r     <= 1'b0;
      direct_addr_bit7_r     <= 1'b0;
      address_latch_strobe_r <= 1'b0;
      store_strobe_n_r       <= 1'b1;
      load_strobe_n_r        <= 1'b1;
      window_select_n_r      <= 1'b1;
      inverted_top_address_r <= 1'b1;
      busy_r                 <= 1'b0;
    end else begin
      port_zero_o_r          <= p0_o_nxt;
      port_zero_oe_r         <= p0_oe_nxt;
      port_zero_pu_r         <= port_zero_pullup_enable; // R2
      port_two_o_r           <= p2_o_nxt;
      port_two_oe_r          <= p2_oe_nxt;
      port_four_addr_r       <= addr_r[5:0]; // R9
      direct_addr_bit6_r     <= addr_r[`A6_BIT]; // R10
      direct_addr_bit7_r     <= addr_r[`A7_BIT];
      address_latch_strobe_r <= (st_r == ST_ALE); // R6
      store_strobe_n_r       <= !(st_r == ST_STRB && wr_r); // R12 R19
      load_strobe_n_r        <= !(st_r == ST_STRB && !wr_r); // R12 R19
      window_select_n_r      <= !(act_nxt && in_win); // R7
      inverted_top_address_r <= ~addr_r[`A15_BIT]; // R8
      busy_r                 <= (st_r != ST_IDLE) || req;
    end
  end

endmodule

// ### test/xbus_pins_props.sv
// Checker for the bus pin controller outputs.
// Assumes binding to xbus_pins; sees its ports only.
`timescale 1ns/1ps
module xbus_pins_props (
  input wire       clk,
  input wire       rst_n,
  input wire [7:0] aux_r,
  input wire [7:0] speed_r,
  input wire       done_r,
  input wire [7:0] port_zero_oe_r,
  input wire [7:0] port_two_o_r,
  input wire       direct_addr_bit7_r,
  input wire       address_latch_strobe_r,
  input wire       store_strobe_n_r,
  input wire       load_strobe_n_r
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire st = !store_strobe_n_r;
  wire ld = !load_strobe_n_r;
  // ==========================================
  // Assertions
  chk_strobes_apart: assert property (!(st && ld))
    else $error("strobes overlap");
  chk_write_drive: assert property (st |-> port_zero_oe_r == 8'hFF)
    else $error("write data not driven");
  chk_read_float: assert property (ld |-> port_zero_oe_r == 8'h00)
    else $error("data driven on read");
  chk_fast_width: assert property (
    $fell(store_strobe_n_r) && speed_r[1:0] == 2'h0 |=> !st)
    else $error("fast strobe too long");
  chk_slow_width: assert property (
    $fell(store_strobe_n_r) && speed_r[1:0] == 2'h3 |-> st[*4] ##1 !st)
    else $error("slow strobe width");
  chk_done_follows: assert property (done_r |-> $past(st || ld))
    else $error("done without strobe");
  chk_a7_pin: assert property (
    !aux_r[0] && st |-> port_two_o_r[7] == direct_addr_bit7_r)
    else $error("direct A7 pin differs");
  chk_latch_mux: assert property (
    address_latch_strobe_r |-> aux_r[0] && port_zero_oe_r == 8'hFF)
    else $error("latch strobe outside mux");
  cover property (st);
  cover property (ld);
  cover property (address_latch_strobe_r);
endmodule
bind xbus_pins xbus_pins_props chk_u (.clk(clk), .rst_n(rst_n),
  .aux_r(aux_r), .speed_r(speed_r), .done_r(done_r),
  .port_zero_oe_r(port_zero_oe_r), .port_two_o_r(port_two_o_r),
  .direct_addr_bit7_r(direct_addr_bit7_r),
  .address_latch_strobe_r(address_latch_strobe_r),
  .store_strobe_n_r(store_strobe_n_r), .load_strobe_n_r(load_strobe_n_r));

// ### test/xbus_sram_model.sv
// Behavioural 32KB SRAM on the external bus pins.
// Assumes registered controller pins on one clock.
`timescale 1ns/1ps
module xbus_sram_model (
  // Controller pins
  input wire       clk,
  input wire       mux,
  input wire [7:0] d_o,
  input wire [7:0] hi,
  input wire [5:0] lo,
  input wire       a6,
  input wire       a7,
  input wire       ale,
  input wire       st_n,
  input wire       ld_n,
  // Read data
  output wire [7:0] d_i
);
  reg [7:0]   mem [0:32767];
  reg [7:0]   lat;
  reg         st_q;
  wire [14:0] a = {hi[6:0], mux ? lat : {a7, a6, lo}};
  always @(posedge clk) begin
    st_q <= st_n;
    if (ale) lat <= d_o;
    if (st_n && !st_q) mem[a] <= d_o;
  end
  // Released bus shows the inverse so a late sample is caught
  assign d_i = ld_n ? ~mem[a] : mem[a];
endmodule

// ### test/external_parallel_bus_pins_bench.sv
// Self-checking bench for the external bus pin controller.
// Assumes xbus_pins, its checker and the SRAM model.
`timescale 1ns/1ps
module external_parallel_bus_pins_bench;
  logic clk = 0, rst_n = 0, req = 0, req_wr = 0, speed_we = 0, aux_we = 0;
  logic [15:0] req_addr = 16'h0000;
  logic [7:0] req_wdata = 8'h00, speed_wdata = 8'h00, aux_wdata = 8'h00;
  logic [7:0] port_zero_out = 8'h5A, port_zero_dir = 8'hFF, port_zero_in;
  logic [7:0] port_zero_pullup_enable = 8'h0F, port_two_out = 8'hC3;
  logic [7:0] port_two_dir = 8'hFF, rdata_r, speed_r, aux_r, port_zero_o_r;
  logic [7:0] port_zero_oe_r, port_zero_pu_r, port_two_o_r, port_two_oe_r;
  logic [5:0] port_four_addr_r;
  logic busy_r, done_r, direct_addr_bit6_r, direct_addr_bit7_r, win, ale;
  logic address_latch_strobe_r, store_strobe_n_r, load_strobe_n_r;
  logic window_select_n_r, inverted_top_address_r;
  int miscompares = 0, checks = 0, sw;
  always #2.5 clk = ~clk;
  xbus_pins #(.SPW(4)) dut_u (.*);
  xbus_sram_model mem_u (.clk(clk), .mux(aux_r[0]), .d_o(port_zero_o_r),
    .hi(port_two_o_r), .lo(port_four_addr_r), .a6(direct_addr_bit6_r),
    .a7(direct_addr_bit7_r), .ale(address_latch_strobe_r),
    .st_n(store_strobe_n_r), .ld_n(load_strobe_n_r), .d_i(port_zero_in));
  // ==========================================
  // Tasks
  task wrap_up;
    if (miscompares == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task ck(input string s, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", s, e, g);
      miscompares++;
    end
  endtask
  task cfg(input logic sp, input logic [7:0] v);
    @(posedge clk);
    speed_we <= sp;
    aux_we <= !sp;
    speed_wdata <= v;
    aux_wdata <= v;
    @(posedge clk);
    speed_we <= 0;
    aux_we <= 0;
  endtask
  task acc(input logic w, input logic [15:0] a, input logic [7:0] d);
    int n;
    {win, ale, sw, n} = 0;
    @(posedge clk);
    req <= 1;
    req_wr <= w;
    req_addr <= a;
    req_wdata <= d;
    @(posedge clk);
    req <= 0;
    do begin
      @(posedge clk);
      #1;
      win |= !window_select_n_r;
      ale |= address_latch_strobe_r;
      sw += !(store_strobe_n_r && load_strobe_n_r);
      n++;
    end while (done_r !== 1'b1 && n < 40);
    if (n == 40) begin
      miscompares++;
      wrap_up;
    end
  endtask
  task t_window;
    logic [15:0] a [4] = '{16'h3FFF, 16'h4000, 16'h7FFF, 16'h8001};
    foreach (a[i]) begin
      acc(1, a[i], a[i][7:0] ^ a[i][15:8]);
      ck("window", a[i][15:14] == 2'h1, win);
      ck("top inv", !a[i][15], inverted_top_address_r);
    end
    foreach (a[i]) begin
      acc(0, a[i], 8'h00);
      ck("read", a[i][7:0] ^ a[i][15:8], rdata_r);
    end
    repeat (3) @(posedge clk);
    #1;
    ck("p0 idle", 16'h00A5, port_zero_oe_r);
    ck("p2 idle", 16'h00C3, port_two_o_r);
    ck("p2 oe idle", 16'h00FF, port_two_oe_r);
    ck("p0 o idle", 16'h005A, port_zero_o_r);
    ck("low addr", 16'h0001, port_four_addr_r);
    ck("busy idle", 16'h0000, busy_r);
  endtask
  task t_speed;
    for (int s = 0; s < 4; s++) begin
      cfg(1, s[7:0]);
      acc(1, 16'h1234, 8'h5A);
      ck("width", s + 1, sw);
    end
  endtask
  task t_mux;
    cfg(0, 8'h01);
    acc(1, 16'h2A96, 8'hE7);
    ck("latch", 16'h0001, ale);
    acc(0, 16'h2A96, 8'h00);
    ck("mux read", 16'h00E7, rdata_r);
    acc(0, 16'h1234, 8'h00);
    ck("cross mode", 16'h005A, rdata_r);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1;
    repeat (3) @(posedge clk);
    #1;
    ck("speed", 16'h00FF, speed_r);
    ck("aux", 16'h0000, aux_r);
    ck("p0 oe", 16'h00A5, port_zero_oe_r);
    ck("port_zero_pullup_enable", 16'h000F, port_zero_pu_r);
    t_window;
    t_speed;
    t_mux;
    wrap_up;
  end
endmodule
